// ---- xbm_pkg.sv ----
// Operation
// - 4-bit region index on both address channels
// - write data tag copies address tag
// - qos propagated on both address channels
// - undriven response codes default to zero
// - undriven sideband inputs default to zero
// - slave always drives readies, valids, data
// - length, size, burst type, lock presented
// - byte strobe width is data width/8
// - one native clock, active-high global reset
// - reset held at least 16 cycles; core passes rst_i straight through, XBM_RST_MIN unused
// - 16 cycles of slowest attached clock
// - per-slot resynchronised active-low reset output
package xbm_pkg;
  localparam int XBM_REGION_W = 4;
  localparam int XBM_QOS_W    = 4;
  localparam int XBM_LEN_W    = 8;
  localparam int XBM_SIZE_W   = 3;
  localparam int XBM_BURST_W  = 2;
  localparam int XBM_LOCK_W   = 2;
  localparam int XBM_CACHE_W  = 4;
  localparam int XBM_PROT_W   = 3;
  localparam int XBM_RESP_W   = 2;
  localparam int XBM_BYTE_W   = 8;
  localparam int XBM_RST_MIN  = 16;
  localparam int XBM_SYNC_LEN = 3;
  localparam logic [1:0] XBM_RESP_OKAY = 2'h0;
  localparam logic [1:0] XBM_BURST_INCR = 2'h1;
endpackage

// ---- xbm_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface xbm_if
  import xbm_pkg::*;
#(
  parameter int ID_W   = 1,
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32,
  parameter int USER_W = 1
);
  logic                    aresetn;
  logic [ID_W-1:0]         awid;
  logic [ADDR_W-1:0]       awaddr;
  logic [XBM_LEN_W-1:0]    awlen;
  logic [XBM_SIZE_W-1:0]   awsize;
  logic [XBM_BURST_W-1:0]  awburst;
  logic [XBM_LOCK_W-1:0]   awlock;
  logic [XBM_CACHE_W-1:0]  awcache;
  logic [XBM_PROT_W-1:0]   awprot;
  logic [XBM_REGION_W-1:0] slot_write_region_index;
  logic [XBM_QOS_W-1:0]    slot_write_qos;
  logic [USER_W-1:0]       awuser;
  logic                    awvalid;
  logic                    awready;
  logic [ID_W-1:0]         slot_write_data_tag;
  logic [DATA_W-1:0]       wdata;
  logic [DATA_W/8-1:0]     wstrb;
  logic                    wlast;
  logic [USER_W-1:0]       wuser;
  logic                    wvalid;
  logic                    wready;
  logic [ID_W-1:0]         bid;
  logic [XBM_RESP_W-1:0]   bresp;
  logic [USER_W-1:0]       slot_write_resp_sideband;
  logic                    bvalid;
  logic                    bready;
  logic [ID_W-1:0]         arid;
  logic [ADDR_W-1:0]       araddr;
  logic [XBM_LEN_W-1:0]    slot_read_burst_length;
  logic [XBM_SIZE_W-1:0]   arsize;
  logic [XBM_BURST_W-1:0]  arburst;
  logic [XBM_LOCK_W-1:0]   arlock;
  logic [XBM_CACHE_W-1:0]  arcache;
  logic [XBM_PROT_W-1:0]   arprot;
  logic [XBM_REGION_W-1:0] slot_read_region_index;
  logic [XBM_QOS_W-1:0]    slot_read_qos;
  logic [USER_W-1:0]       aruser;
  logic                    arvalid;
  logic                    arready;
  logic [ID_W-1:0]         rid;
  logic [DATA_W-1:0]       rdata;
  logic [XBM_RESP_W-1:0]   rresp;
  logic                    slot_read_final_beat;
  logic [USER_W-1:0]       slot_read_data_sideband;
  logic                    rvalid;
  logic                    rready;

  modport core (
    output aresetn, awid, awaddr, awlen, awsize, awburst, awlock, awcache, awprot,
           slot_write_region_index, slot_write_qos, awuser, awvalid,
           slot_write_data_tag, wdata, wstrb, wlast, wuser, wvalid, bready,
           arid, araddr, slot_read_burst_length, arsize, arburst, arlock, arcache,
           arprot, slot_read_region_index, slot_read_qos, aruser, arvalid, rready,
    input  awready, wready, bid, bresp, slot_write_resp_sideband, bvalid,
           arready, rid, rdata, rresp, slot_read_final_beat,
           slot_read_data_sideband, rvalid
  );
  modport slave (
    input  aresetn, awid, awaddr, awlen, awsize, awburst, awlock, awcache, awprot,
           slot_write_region_index, slot_write_qos, awuser, awvalid,
           slot_write_data_tag, wdata, wstrb, wlast, wuser, wvalid, bready,
           arid, araddr, slot_read_burst_length, arsize, arburst, arlock, arcache,
           arprot, slot_read_region_index, slot_read_qos, aruser, arvalid, rready,
    output awready, wready, bid, bresp, slot_write_resp_sideband, bvalid,
           arready, rid, rdata, rresp, slot_read_final_beat,
           slot_read_data_sideband, rvalid
  );
endinterface
`default_nettype wire

// ---- xbm_rst_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module xbm_rst_sync
  import xbm_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      slot_reset_out_low_o
);
  logic [XBM_SYNC_LEN-1:0] stage;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage <= '0;
    end else begin
      stage <= {stage[XBM_SYNC_LEN-2:0], 1'b1};
    end
  end

  assign slot_reset_out_low_o = stage[XBM_SYNC_LEN-1];
endmodule
`default_nettype wire

// ---- xbm_core_end.sv ----
`timescale 1ns/100ps
`default_nettype none
module xbm_core_end
  import xbm_pkg::*;
#(
  parameter int ID_W   = 1,
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32,
  parameter int USER_W = 1
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // write request
  input  wire logic                    wr_req_i,
  input  wire logic [ID_W-1:0]         wr_id_i,
  input  wire logic [ADDR_W-1:0]       wr_addr_i,
  input  wire logic [DATA_W-1:0]       wr_data_i,
  input  wire logic [DATA_W/8-1:0]     wr_strb_i,
  input  wire logic [XBM_REGION_W-1:0] wr_region_i,
  input  wire logic [XBM_QOS_W-1:0]    wr_qos_i,
  output logic                         wr_busy_o,
  output logic                         wr_done_o,
  output logic [XBM_RESP_W-1:0]        wr_resp_o,
  output logic [USER_W-1:0]            wr_user_o,
  // read request
  input  wire logic                    rd_req_i,
  input  wire logic [ID_W-1:0]         rd_id_i,
  input  wire logic [ADDR_W-1:0]       rd_addr_i,
  input  wire logic [XBM_LEN_W-1:0]    rd_len_i,
  input  wire logic [XBM_REGION_W-1:0] rd_region_i,
  input  wire logic [XBM_QOS_W-1:0]    rd_qos_i,
  output logic                         rd_busy_o,
  output logic                         rd_beat_o,
  output logic                         rd_last_o,
  output logic [DATA_W-1:0]            rd_data_o,
  output logic [XBM_RESP_W-1:0]        rd_resp_o,
  output logic [USER_W-1:0]            rd_user_o,
  xbm_if.core                          bus
);
  localparam logic [XBM_SIZE_W-1:0] FULL_SIZE = XBM_SIZE_W'($clog2(DATA_W / XBM_BYTE_W));

  logic slot_rst_low;
  logic core_rst;

  assign core_rst = rst_i;

  xbm_rst_sync u_rst (
    .clk_i                (clk_i),
    .rst_i                (core_rst),
    .slot_reset_out_low_o (slot_rst_low)
  );
  assign bus.aresetn = slot_rst_low;

  // no start while slot in reset
  logic wr_take;
  logic rd_take;
  assign wr_take = wr_req_i && !wr_busy_o && slot_rst_low;
  assign rd_take = rd_req_i && !rd_busy_o && slot_rst_low;

  // ----------------------------------------
  // write channels
  // ----------------------------------------
  logic aw_pend;
  logic w_pend;
  logic b_wait;

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      aw_pend <= 1'b0;
      w_pend  <= 1'b0;
      b_wait  <= 1'b0;
    end else if (wr_take) begin
      aw_pend <= 1'b1;
      w_pend  <= 1'b1;
      b_wait  <= 1'b1;
    end else begin
      if (aw_pend && bus.awready) aw_pend <= 1'b0;
      if (w_pend && bus.wready) w_pend <= 1'b0;
      if (b_wait && !aw_pend && !w_pend && bus.bvalid) b_wait <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      bus.awid                    <= '0;
      bus.awaddr                  <= '0;
      bus.slot_write_region_index <= '0;
      bus.slot_write_qos          <= '0;
      bus.slot_write_data_tag     <= '0;
      bus.wdata                   <= '0;
      bus.wstrb                   <= '0;
    end else if (wr_take) begin
      bus.awid                    <= wr_id_i;
      bus.awaddr                  <= wr_addr_i;
      bus.slot_write_region_index <= wr_region_i;
      bus.slot_write_qos          <= wr_qos_i;
      bus.slot_write_data_tag     <= wr_id_i;
      bus.wdata                   <= wr_data_i;
      bus.wstrb                   <= wr_strb_i;
    end
  end

  assign bus.awlen   = '0;
  assign bus.awsize  = FULL_SIZE;
  assign bus.awburst = XBM_BURST_INCR;
  assign bus.awlock  = '0;
  assign bus.awcache = '0;
  assign bus.awprot  = '0;
  assign bus.awuser  = '0;
  assign bus.wuser   = '0;
  assign bus.wlast   = 1'b1;
  assign bus.awvalid = aw_pend;
  assign bus.wvalid  = w_pend;
  assign bus.bready  = b_wait && !aw_pend && !w_pend;

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      wr_busy_o <= 1'b0;
      wr_done_o <= 1'b0;
      wr_resp_o <= XBM_RESP_OKAY;
      wr_user_o <= '0;
    end else begin
      wr_busy_o <= wr_take || (b_wait && !(bus.bready && bus.bvalid));
      wr_done_o <= bus.bready && bus.bvalid;
      if (bus.bready && bus.bvalid) begin
        wr_resp_o <= bus.bresp;
        wr_user_o <= bus.slot_write_resp_sideband;
      end
    end
  end

  // ----------------------------------------
  // read channels
  // ----------------------------------------
  logic ar_pend;
  logic r_wait;

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      ar_pend <= 1'b0;
      r_wait  <= 1'b0;
    end else if (rd_take) begin
      ar_pend <= 1'b1;
      r_wait  <= 1'b1;
    end else begin
      if (ar_pend && bus.arready) ar_pend <= 1'b0;
      if (r_wait && !ar_pend && bus.rvalid && bus.slot_read_final_beat) r_wait <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      bus.arid                   <= '0;
      bus.araddr                 <= '0;
      bus.slot_read_burst_length <= '0;
      bus.slot_read_region_index <= '0;
      bus.slot_read_qos          <= '0;
    end else if (rd_take) begin
      bus.arid                   <= rd_id_i;
      bus.araddr                 <= rd_addr_i;
      bus.slot_read_burst_length <= rd_len_i;
      bus.slot_read_region_index <= rd_region_i;
      bus.slot_read_qos          <= rd_qos_i;
    end
  end

  assign bus.arsize  = FULL_SIZE;
  assign bus.arburst = XBM_BURST_INCR;
  assign bus.arlock  = '0;
  assign bus.arcache = '0;
  assign bus.arprot  = '0;
  assign bus.aruser  = '0;
  assign bus.arvalid = ar_pend;
  assign bus.rready  = r_wait && !ar_pend;

  always_ff @(posedge clk_i) begin
    if (core_rst) begin
      rd_busy_o <= 1'b0;
      rd_beat_o <= 1'b0;
      rd_last_o <= 1'b0;
      rd_data_o <= '0;
      rd_resp_o <= XBM_RESP_OKAY;
      rd_user_o <= '0;
    end else begin
      rd_busy_o <= rd_take ||
                   (r_wait && !(bus.rready && bus.rvalid && bus.slot_read_final_beat));
      rd_beat_o <= bus.rready && bus.rvalid;
      rd_last_o <= bus.rready && bus.rvalid && bus.slot_read_final_beat;
      if (bus.rready && bus.rvalid) begin
        rd_data_o <= bus.rdata;
        rd_resp_o <= bus.rresp;
        rd_user_o <= bus.slot_read_data_sideband;
      end
    end
  end
endmodule
`default_nettype wire

// ---- xbm_slave_end.sv ----
`timescale 1ns/100ps
`default_nettype none
module xbm_slave_end
  import xbm_pkg::*;
#(
  parameter int ID_W   = 1,
  parameter int ADDR_W = 32,
  parameter int DATA_W = 32,
  parameter int USER_W = 1,
  parameter int DEPTH  = 16
) (
  input  wire logic              clk_i,
  output logic                   slv_rst_o,
  output logic                   wr_seen_o,
  output logic [ADDR_W-1:0]      wr_addr_o,
  output logic [XBM_QOS_W-1:0]   wr_qos_o,
  input  wire logic [XBM_RESP_W-1:0] resp_i,
  xbm_if.slave                   bus
);
  localparam int AW = $clog2(DEPTH);
  logic [DATA_W-1:0] mem [DEPTH];
  logic [XBM_RESP_W-1:0] resp_q;
  logic rst;
  logic aw_ok;
  logic w_ok;
  logic b_v;
  logic [ID_W-1:0] b_id;
  logic [ADDR_W-1:0] w_addr;
  logic r_act;
  logic [ID_W-1:0] r_id;
  logic [ADDR_W-1:0] r_addr;
  logic [XBM_LEN_W-1:0] r_left;
  logic aw_seen;
  logic ar_seen;

  function automatic logic [AW-1:0] word_idx(input logic [ADDR_W-1:0] a);
    return a[AW+$clog2(DATA_W/XBM_BYTE_W)-1 -: AW];
  endfunction

  assign rst = !bus.aresetn;

  always_ff @(posedge clk_i) begin
    slv_rst_o <= rst;
    resp_q    <= resp_i;
  end

  assign bus.awready = !aw_ok && !b_v && aw_seen;
  assign bus.wready  = !w_ok && !b_v;
  assign bus.bvalid  = b_v;
  assign bus.bid     = b_id;
  assign bus.bresp   = resp_q;
  assign bus.slot_write_resp_sideband = '0;
  assign bus.arready = !r_act && ar_seen;

  // address ready one cycle after valid, so requests wait
  always_ff @(posedge clk_i) begin
    if (rst) begin
      aw_seen <= 1'b0;
      ar_seen <= 1'b0;
    end else begin
      aw_seen <= bus.awvalid && !bus.awready;
      ar_seen <= bus.arvalid && !bus.arready;
    end
  end
  assign bus.rvalid  = r_act;
  assign bus.rid     = r_id;
  assign bus.rdata   = mem[word_idx(r_addr)];
  assign bus.rresp   = resp_q;
  assign bus.slot_read_final_beat = r_act && (r_left == '0);
  assign bus.slot_read_data_sideband = '0;

  always_ff @(posedge clk_i) begin
    if (rst) begin
      aw_ok     <= 1'b0;
      w_ok      <= 1'b0;
      b_v       <= 1'b0;
      b_id      <= '0;
      w_addr    <= '0;
      wr_seen_o <= 1'b0;
      wr_addr_o <= '0;
      wr_qos_o  <= '0;
    end else begin
      wr_seen_o <= 1'b0;
      if (bus.awvalid && bus.awready) begin
        aw_ok     <= 1'b1;
        w_addr    <= bus.awaddr;
        b_id      <= bus.awid;
        wr_qos_o  <= bus.slot_write_qos;
        wr_addr_o <= bus.awaddr;
      end
      if (bus.wvalid && bus.wready) w_ok <= 1'b1;
      if (aw_ok && w_ok && !b_v) begin
        b_v       <= 1'b1;
        wr_seen_o <= 1'b1;
        aw_ok     <= 1'b0;
        w_ok      <= 1'b0;
      end
      if (b_v && bus.bready) b_v <= 1'b0;
    end
  end

  logic [DATA_W-1:0] w_hold;
  logic [DATA_W/8-1:0] s_hold;
  always_ff @(posedge clk_i) begin
    if (bus.wvalid && bus.wready) begin
      w_hold <= bus.wdata;
      s_hold <= bus.wstrb;
    end
    if (aw_ok && w_ok && !b_v) begin
      for (int i = 0; i < DATA_W / XBM_BYTE_W; i++) begin
        if (s_hold[i]) mem[word_idx(w_addr)][i*XBM_BYTE_W +: XBM_BYTE_W] <= w_hold[i*XBM_BYTE_W +: XBM_BYTE_W];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst) begin
      r_act  <= 1'b0;
      r_id   <= '0;
      r_addr <= '0;
      r_left <= '0;
    end else if (bus.arvalid && bus.arready) begin
      r_act  <= 1'b1;
      r_id   <= bus.arid;
      r_addr <= bus.araddr;
      r_left <= bus.slot_read_burst_length;
    end else if (r_act && bus.rready) begin
      if (r_left == '0) begin
        r_act <= 1'b0;
      end else begin
        r_left <= r_left - 1'b1;
        r_addr <= r_addr + ADDR_W'(DATA_W / XBM_BYTE_W);
      end
    end
  end
endmodule
`default_nettype wire

// ---- xbm_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
module xbm_asserts
  import xbm_pkg::*;
#(
  parameter int ID_W   = 1,
  parameter int DATA_W = 32
) (
  input wire logic                    clk_i,
  input wire logic                    rst_i,
  input wire logic                    aresetn,
  input wire logic [ID_W-1:0]         awid,
  input wire logic [ID_W-1:0]         slot_write_data_tag,
  input wire logic [XBM_LEN_W-1:0]    awlen,
  input wire logic [XBM_SIZE_W-1:0]   awsize,
  input wire logic [XBM_BURST_W-1:0]  awburst,
  input wire logic [XBM_REGION_W-1:0] slot_write_region_index,
  input wire logic [XBM_QOS_W-1:0]    slot_write_qos,
  input wire logic                    awvalid,
  input wire logic                    awready,
  input wire logic                    wvalid,
  input wire logic                    wlast,
  input wire logic [XBM_LEN_W-1:0]    slot_read_burst_length,
  input wire logic [XBM_SIZE_W-1:0]   arsize,
  input wire logic [XBM_BURST_W-1:0]  arburst,
  input wire logic [XBM_REGION_W-1:0] slot_read_region_index,
  input wire logic [XBM_QOS_W-1:0]    slot_read_qos,
  input wire logic                    arvalid,
  input wire logic                    arready
);
  localparam int SIZE = $clog2(DATA_W / XBM_BYTE_W);
  default clocking cb @(posedge clk_i); endclocking
  // ----------------------------------------
  // sequences
  // ----------------------------------------
  sequence s_release;
    !aresetn ##[1:4] aresetn;
  endsequence
  sequence s_aw_held;
    awvalid && $stable(slot_write_region_index) && $stable(slot_write_qos);
  endsequence
  sequence s_ar_held;
    arvalid && $stable(slot_read_region_index) && $stable(slot_read_qos)
      && $stable(slot_read_burst_length);
  endsequence
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_aw_hold;
    disable iff (rst_i) awvalid && !awready |=> s_aw_held;
  endproperty
  a_aw_hold: assert property (p_aw_hold) else $error("aw payload moved");
  property p_ar_hold;
    disable iff (rst_i) arvalid && !arready |=> s_ar_held;
  endproperty
  a_ar_hold: assert property (p_ar_hold) else $error("ar payload moved");
  property p_tag_copy;
    disable iff (rst_i) wvalid |-> slot_write_data_tag == awid;
  endproperty
  a_tag_copy: assert property (p_tag_copy) else $error("data tag differs");
  property p_aw_shape;
    disable iff (rst_i) awvalid |-> awlen == 8'h0 && awsize == SIZE && awburst == XBM_BURST_INCR;
  endproperty
  a_aw_shape: assert property (p_aw_shape) else $error("aw shape wrong");
  property p_ar_shape;
    disable iff (rst_i) arvalid |-> arsize == SIZE && arburst == XBM_BURST_INCR;
  endproperty
  a_ar_shape: assert property (p_ar_shape) else $error("ar shape wrong");
  property p_single_beat;
    disable iff (rst_i) wvalid |-> wlast;
  endproperty
  a_single_beat: assert property (p_single_beat) else $error("wlast low");
  property p_reset_low;
    rst_i |=> !aresetn;
  endproperty
  a_reset_low: assert property (p_reset_low) else $error("slot reset high");
  property p_reset_release;
    $fell(rst_i) |-> s_release;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("slot reset late");
  property p_quiet;
    rst_i |=> !awvalid && !wvalid && !arvalid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("valid in reset");
endmodule
`default_nettype wire

// ---- crossbar_master_side_ports_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module crossbar_master_side_ports_test;
  import xbm_pkg::*;
  logic        clk_i = 1'b0, rst_i = 1'b1, wr_req_i = 1'b0, rd_req_i = 1'b0;
  logic [0:0]  wr_id_i = '0, rd_id_i = '0, wr_user_o, rd_user_o;
  logic [31:0] wr_addr_i = '0, wr_data_i = '0, rd_addr_i = '0, rd_data_o, wr_addr_o;
  logic [3:0]  wr_strb_i = '0, wr_region_i = '0, wr_qos_i = '0, rd_region_i = '0;
  logic [3:0]  rd_qos_i = '0, wr_qos_o, cap_wreg, cap_rreg, cap_rqos, s;
  logic [7:0]  rd_len_i = '0, cap_len, len;
  logic [1:0]  resp_i = '0, wr_resp_o, rd_resp_o;
  logic        wr_busy_o, wr_done_o, rd_busy_o, rd_beat_o, rd_last_o, slv_rst_o, wr_seen_o;
  logic [31:0] a, d, old;
  int          fail_count = 0, comparisons = 0, cyc = 0, beats, seen = 0;
  xbm_if xbm_if_i ();
  xbm_core_end xbm_core_end_i (
    .clk_i(clk_i), .rst_i(rst_i), .wr_req_i(wr_req_i), .wr_id_i(wr_id_i),
    .wr_addr_i(wr_addr_i), .wr_data_i(wr_data_i), .wr_strb_i(wr_strb_i),
    .wr_region_i(wr_region_i), .wr_qos_i(wr_qos_i), .wr_busy_o(wr_busy_o),
    .wr_done_o(wr_done_o), .wr_resp_o(wr_resp_o), .wr_user_o(wr_user_o),
    .rd_req_i(rd_req_i), .rd_id_i(rd_id_i), .rd_addr_i(rd_addr_i), .rd_len_i(rd_len_i),
    .rd_region_i(rd_region_i), .rd_qos_i(rd_qos_i), .rd_busy_o(rd_busy_o),
    .rd_beat_o(rd_beat_o), .rd_last_o(rd_last_o), .rd_data_o(rd_data_o),
    .rd_resp_o(rd_resp_o), .rd_user_o(rd_user_o), .bus(xbm_if_i));
  xbm_slave_end xbm_slave_end_i (
    .clk_i(clk_i), .slv_rst_o(slv_rst_o), .wr_seen_o(wr_seen_o), .wr_addr_o(wr_addr_o),
    .wr_qos_o(wr_qos_o), .resp_i(resp_i), .bus(xbm_if_i));
  xbm_asserts xbm_asserts_i (
    .clk_i(clk_i), .rst_i(rst_i), .aresetn(xbm_if_i.aresetn), .awid(xbm_if_i.awid),
    .slot_write_data_tag(xbm_if_i.slot_write_data_tag), .awlen(xbm_if_i.awlen),
    .awsize(xbm_if_i.awsize), .awburst(xbm_if_i.awburst),
    .slot_write_region_index(xbm_if_i.slot_write_region_index),
    .slot_write_qos(xbm_if_i.slot_write_qos), .awvalid(xbm_if_i.awvalid),
    .awready(xbm_if_i.awready), .wvalid(xbm_if_i.wvalid), .wlast(xbm_if_i.wlast),
    .slot_read_burst_length(xbm_if_i.slot_read_burst_length), .arsize(xbm_if_i.arsize),
    .arburst(xbm_if_i.arburst), .slot_read_region_index(xbm_if_i.slot_read_region_index),
    .slot_read_qos(xbm_if_i.slot_read_qos), .arvalid(xbm_if_i.arvalid),
    .arready(xbm_if_i.arready));
  always #5 clk_i = ~clk_i;
  // ----------------------------------------
  // address channel capture and write completion count
  // ----------------------------------------
  always @(posedge clk_i) begin
    if (wr_seen_o === 1'b1)
      seen <= seen + 1;
    if (xbm_if_i.awvalid && xbm_if_i.awready)
      cap_wreg <= xbm_if_i.slot_write_region_index;
    if (xbm_if_i.arvalid && xbm_if_i.arready) begin
      cap_rreg <= xbm_if_i.slot_read_region_index;
      cap_rqos <= xbm_if_i.slot_read_qos;
      cap_len <= xbm_if_i.slot_read_burst_length;
    end
  end
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] st);
    for (int b = 0; b < 4; b++)
      if (st[b]) o[8*b +: 8] = n[8*b +: 8];
    return o;
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [31:0] wa, wd, input logic [3:0] ws);
    int n;
    wr_id_i = 1'($urandom);
    wr_region_i = 4'($urandom);
    wr_qos_i = 4'($urandom);
    wr_addr_i = wa;
    wr_data_i = wd;
    wr_strb_i = ws;
    wr_req_i = 1'b1;
    @(posedge clk_i);
    #1 wr_req_i = 1'b0;
    for (n = 0; n < 50 && wr_done_o !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    cmp(32'(wr_done_o), 32'h1);
    cmp(32'(wr_busy_o), 32'h0);
    cmp(32'(wr_user_o), 32'h0);
  endtask
  task automatic rd(input logic [31:0] ra, input logic [7:0] rl, output int nb);
    int n;
    nb = 0;
    rd_id_i = 1'($urandom);
    rd_region_i = 4'($urandom);
    rd_qos_i = 4'($urandom);
    rd_addr_i = ra;
    rd_len_i = rl;
    rd_req_i = 1'b1;
    @(posedge clk_i);
    #1 rd_req_i = 1'b0;
    for (n = 0; n < 400; n++) begin
      if (rd_beat_o === 1'b1) nb++;
      if (rd_last_o === 1'b1) break;
      @(posedge clk_i);
      #1;
    end
    cmp(32'(rd_last_o), 32'h1);
    cmp(32'(rd_busy_o), 32'h0);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(52610));
    for (int p = 0; p < 2; p++) begin
      rst_i = 1'b1;
      repeat (20) @(posedge clk_i);
      #1;
      cmp(32'(slv_rst_o), 32'h1);
      rst_i = 1'b0;
      repeat (6) @(posedge clk_i);
      #1;
      cmp(32'(slv_rst_o), 32'h0);
      for (int i = 0; i < 8; i++) begin
        a = {26'h0, 4'($urandom), 2'h0};
        d = $urandom;
        s = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($urandom);
        resp_i = 2'(i);
        wr(a, $urandom, 4'hf);
        cmp(32'(wr_resp_o), 32'(resp_i));
        cmp(32'(wr_qos_o), 32'(wr_qos_i));
        cmp(32'(cap_wreg), 32'(wr_region_i));
        cmp(wr_addr_o, a);
        old = wr_data_i;
        wr(a, d, s);
        rd(a, 8'h0, beats);
        cmp(rd_data_o, merge(old, d, s));
        cmp(32'(rd_resp_o), 32'(resp_i));
        cmp(32'(rd_user_o), 32'h0);
        cmp(32'(cap_rreg), 32'(rd_region_i));
        cmp(32'(cap_rqos), 32'(rd_qos_i));
        len = (i == 7) ? 8'hff : 8'($urandom_range(1, 15));
        rd(a, len, beats);
        cmp(32'(beats), 32'(len) + 32'h1);
        cmp(32'(cap_len), 32'(len));
      end
      $display("pass %0d done", p);
    end
    cmp(32'(seen), 32'h20);
    conclude();
  end
endmodule
`default_nettype wire
